// ==== dv/pfr_nvm_model.sv ====
// pfr_nvm_model.sv: nvm write side of the recorder, keeps the newest slot
// assumes: one-cycle record strobes on clk
`timescale 1ns/1ps
module pfr_nvm_model (
    // write side
    input wire clk,
    input wire rec_we,
    input wire [303:0] rec_data,
    // observation
    output reg [303:0] slot,
    output integer n_rec
);
    initial n_rec = 0;
    always @(posedge clk)
        if (rec_we === 1'b1)
        begin
            slot <= rec_data;
            n_rec <= n_rec + 1;
        end
endmodule // pfr_nvm_model

// ==== dv/pfr_recorder_asserts.sv ====
// pfr_recorder_asserts.sv: port checks for pfr_recorder
// assumes: one clk domain, synchronous active-low resetn
`timescale 1ns/1ps
module pfr_recorder_asserts #(
    parameter NEV = 6
)(
    // clock, reset, inputs
    input wire clk,
    input wire resetn,
    input wire ac_present,
    input wire power_on_request_n,
    input wire cnt_load,
    input wire [NEV-1:0] shutdown_status,
    // outputs
    input wire cnt_nvm_we,
    input wire [23:0] cnt_nvm_data,
    input wire rec_nvm_we,
    input wire [303:0] rec_nvm_data,
    input wire [15:0] ac_cycles,
    input wire [15:0] power_on_request_n_cycles
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    strobe_on_rise_a: assert property (
        |(shutdown_status & ~$past(shutdown_status)) && !cnt_load |=> cnt_nvm_we) else $error("no strobe");
    strobe_pair_a: assert property (cnt_nvm_we |-> rec_nvm_we) else $error("no record");
    load_drop_a: assert property (cnt_load |=> !cnt_nvm_we) else $error("load strobe");
    rec_counts_a: assert property (
        rec_nvm_we |-> rec_nvm_data[263:240] == cnt_nvm_data) else $error("counts");
    rec_tail_a: assert property (rec_nvm_we |-> rec_nvm_data[303:264] == 0) else $error("tail");
    // a reload may lower the image; the bench loads only once
    sat_hold_a: assert property (
        cnt_nvm_we && $past(cnt_nvm_data[3:0]) == 4'hf |-> cnt_nvm_data[3:0] == 4'hf) else $error("wrap");
    // both pins pass a two-flop synchroniser, so a count lands three edges after its pin edge
    ac_count_a: assert property (
        $rose(ac_present) && !power_on_request_n && $past(resetn) && ac_cycles != 16'hffff
        |-> ##3 ac_cycles == $past(ac_cycles) + 16'h0001) else $error("ac count");
    power_on_request_n_count_a: assert property (
        $fell(power_on_request_n) && ac_present && $past(ac_present) && $past(resetn) && power_on_request_n_cycles != 16'hffff
        |-> ##3 power_on_request_n_cycles == $past(power_on_request_n_cycles) + 16'h0001) else $error("power_on_request_n count");
    cover property (rec_nvm_we);
    cover property (cnt_nvm_we && cnt_nvm_data[3:0] == 4'hf);
    cover property ($fell(power_on_request_n) && ac_present);
endmodule // pfr_recorder_asserts
bind pfr_recorder pfr_recorder_asserts #(.NEV(NEV)) u_pfr_recorder_asserts (.clk, .resetn, .ac_present,
    .power_on_request_n, .cnt_load, .shutdown_status, .cnt_nvm_we, .cnt_nvm_data, .rec_nvm_we,
    .rec_nvm_data, .ac_cycles, .power_on_request_n_cycles);

// ==== dv/psu_fault_event_recorder_tb.sv ====
// psu_fault_event_recorder_tb.sv: directed scenarios for the fault event recorder
// assumes: recorder, checker and nvm model compiled first
`timescale 1ns/1ps
module psu_fault_event_recorder_tb;
    reg clk = 0, resetn = 0, ac = 0, rq = 1, ld = 0;
    reg [5:0] st = 0;
    reg [31:0] rtc = 0;
    reg [15:0] v = 0, xa = 0, xp = 0;
    reg [3:0] e [0:5];
    wire [23:0] ex = {e[5], e[4], e[3], e[2], e[1], e[0]};
    integer fails = 0, n_compared = 0, cyc = 0, n = 0, nrec, i, j;
    wire cw, rw;
    wire [23:0] cd;
    wire [303:0] rd, slot;
    wire [15:0] acc, psc;
    always #2.5 clk = ~clk;
    pfr_recorder u_pfr_recorder (.clk, .resetn, .ac_present(ac), .power_on_request_n(rq), .rtc_seconds(rtc),
        .cnt_load(ld), .cnt_load_data(24'h00_000e), .shutdown_status(st), .status_word(v), .status_iout(v[7:0]),
        .status_input(v[7:0]), .status_temp(v[7:0]), .status_fan(v[7:0]), .read_vin(v), .read_iin(v),
        .read_iout(v), .read_temp1(v), .read_temp2(v), .read_fan(v), .read_pin(v), .read_vout(v),
        .cnt_nvm_we(cw), .cnt_nvm_data(cd), .rec_nvm_we(rw), .rec_nvm_data(rd), .ac_cycles(acc), .power_on_request_n_cycles(psc));
    pfr_nvm_model u_pfr_nvm_model (.clk, .rec_we(rw), .rec_data(rd), .slot, .n_rec(nrec));
    task end_of_test;
        begin
            $display("compared %0d failed %0d", n_compared, fails);
            if (fails == 0 && n_compared > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task ck(input [303:0] a, input [303:0] b);
        begin
            n_compared++;
            if (a !== b)
            begin
                fails++;
                $display("CHECK FAILED %0t value mismatch", $time);
            end
        end
    endtask
    task t_event(input integer b);
        integer k;
        begin
            rtc <= rtc + 32'h0001_0003;
            v <= v + 16'h1357;
            st[b] <= 1'b1;
            n = n + 1;
            if (e[b] != 4'hf)
                e[b] = e[b] + 4'h1;
            for (k = 0; k < 8 && rw !== 1'b1; k = k + 1)
                @(posedge clk) #1;
            ck(rw, 1'b1);
            ck(cw, 1'b1);
            ck(rd, {40'h0, ex, {8{v}}, {4{v[7:0]}}, v, xp, xa, rtc});
            ck(rd[31:0], rtc);
            ck(rd[79:64], v);
            ck(cd, {e[5], e[4], e[3], e[2], e[1], e[0]});
            // bit left standing so a second strobe would show
            repeat (3) @(posedge clk);
            st[b] <= 1'b0;
            ck(nrec, n);
            ck(slot, rd);
            $display("event %0d done", b);
        end
    endtask
    task t_cycles;
        begin
            ac <= 1'b1;
            @(posedge clk);
            rq <= 1'b0;
            @(posedge clk);
            ac <= 1'b0;
            @(posedge clk);
            ac <= 1'b1;
            // pins pass two synchroniser flops before the counters see them
            repeat (5) @(posedge clk);
            #1;
            ck(acc, 16'h0001);
            ck(psc, 16'h0001);
            xa = 16'h0001;
            xp = 16'h0001;
            @(posedge clk);
            $display("cycle counters done");
        end
    endtask
    always @(posedge clk)
        if (++cyc == 3000)
        begin
            fails++;
            end_of_test;
        end
    initial
    begin
        for (i = 0; i < 6; i = i + 1)
            e[i] = 4'h0;
        e[0] = 4'he;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        ld <= 1'b1;
        @(posedge clk);
        ld <= 1'b0;
        for (j = 0; j < 2; j = j + 1)
            for (i = 0; i < 6; i = i + 1)
                t_event(i);
        t_cycles;
        t_event(5);
        end_of_test;
    end
endmodule // psu_fault_event_recorder_tb

// ==== hw/pfr_map.vh ====
// pfr_map.vh: field layout and byte offsets of the fault event record, and recorder reset values
// assumes: included by bare name from the recorder module
`ifndef PFR_MAP_VH
`define PFR_MAP_VH
// record size in bytes
`define PFR_REC_BYTES 38
// record byte offsets
`define PFR_OFF_TIME 0
`define PFR_OFF_AC_CYC 4
`define PFR_OFF_POWER_ON_REQUEST_N_CYC 6
`define PFR_OFF_STATUS_WORD 8
`define PFR_OFF_STATUS_IOUT 10
`define PFR_OFF_STATUS_INPUT 11
`define PFR_OFF_STATUS_TEMP 12
`define PFR_OFF_STATUS_FAN 13
`define PFR_OFF_READ_VIN 14
`define PFR_OFF_READ_IIN 16
`define PFR_OFF_READ_IOUT 18
`define PFR_OFF_READ_TEMP1 20
`define PFR_OFF_READ_TEMP2 22
`define PFR_OFF_READ_FAN 24
`define PFR_OFF_READ_PIN 26
`define PFR_OFF_READ_VOUT 28
`define PFR_OFF_CNT0 30
`define PFR_OFF_CNT1 31
`define PFR_OFF_CNT2 32
// shutdown counter indices, in nibble order
`define PFR_EV_UV_IN 0
`define PFR_EV_THERMAL 1
`define PFR_EV_OC_OP 2
`define PFR_EV_GENERAL 3
`define PFR_EV_FAN 4
`define PFR_EV_OV_OUT 5
`define PFR_EV_COUNT 6
// saturation values
`define PFR_CNT_MAX 4'hf
`define PFR_CYC_MAX 16'hffff
// reset values: power cycle counts, pin pipe {request_n, ac} idle, warm-up count
`define PFR_CYC_RST 16'h0000
`define PFR_PIN_RST 2'h2
`define PFR_WARM_RST 2'h0
// edges after reset until the pin edge history is valid
`define PFR_WARM_DONE 2'h3
`endif

// ==== hw/pfr_recorder.v ====
// pfr_recorder.v: builds a fault event record and emits it and the shutdown counters to nvm.
// assumes: telemetry, status and fault bits arrive synchronous to clk; ac_present and
// power_on_request_n are asynchronous pins; the nvm side accepts a one-cycle write strobe
// at any time; the counter image is loaded once at start.
`timescale 1ns/1ps
`include "pfr_map.vh"

module pfr_recorder #(
    parameter NEV = `PFR_EV_COUNT
)(
    // clock and reset
    input wire clk,
    input wire resetn,
    // supply state
    input wire ac_present,
    input wire power_on_request_n,
    input wire [31:0] rtc_seconds,
    // counter image from nvm
    input wire cnt_load,
    input wire [23:0] cnt_load_data,
    // shutdown status bits, one per counter
    input wire [NEV-1:0] shutdown_status,
    // pmbus snapshot sources
    input wire [15:0] status_word,
    input wire [7:0] status_iout,
    input wire [7:0] status_input,
    input wire [7:0] status_temp,
    input wire [7:0] status_fan,
    input wire [15:0] read_vin,
    input wire [15:0] read_iin,
    input wire [15:0] read_iout,
    input wire [15:0] read_temp1,
    input wire [15:0] read_temp2,
    input wire [15:0] read_fan,
    input wire [15:0] read_pin,
    input wire [15:0] read_vout,
    // nvm write side
    output reg cnt_nvm_we,
    output reg [23:0] cnt_nvm_data,
    output reg rec_nvm_we,
    output reg [8*`PFR_REC_BYTES-1:0] rec_nvm_data,
    output reg [15:0] ac_cycles,
    output reg [15:0] power_on_request_n_cycles
);

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    // ac and request are raw pins; each passes two flops before any logic looks at it
    reg [1:0] pin_s1;
    reg [1:0] pin_s2;
    // the edge history is meaningless until the pipe has refilled after reset,
    // so a power cycle that lands in the first three edges is not counted
    reg [1:0] warm;
    wire armed = (warm == `PFR_WARM_DONE);

    always @(posedge clk)
    begin
        if (!resetn)
        begin
            pin_s1 <= `PFR_PIN_RST;
            pin_s2 <= `PFR_PIN_RST;
            warm <= `PFR_WARM_RST;
        end
        else
        begin
            pin_s1 <= {power_on_request_n, ac_present};
            pin_s2 <= pin_s1;
            if (!armed)
            begin
                warm <= warm + 2'h1;
            end
        end
    end

    // ************************************************************
    // power cycle counters
    // ************************************************************
    reg ac_d;
    reg req_d;
    wire ac_sync = pin_s2[0];
    wire req_on = ~pin_s2[1];
    // an off-to-on return of ac while requested, or of request while ac stays
    wire ac_cycle = armed & ac_sync & ~ac_d & req_on;
    wire req_cycle = armed & req_on & ~req_d & ac_sync & ac_d;

    always @(posedge clk)
    begin
        if (!resetn)
        begin
            ac_d <= 1'b0;
            req_d <= 1'b0;
            ac_cycles <= `PFR_CYC_RST;
            power_on_request_n_cycles <= `PFR_CYC_RST;
        end
        else
        begin
            ac_d <= ac_sync;
            req_d <= req_on;
            // both counters stick at full scale rather than wrap to zero
            if (ac_cycle && ac_cycles != `PFR_CYC_MAX)
            begin
                ac_cycles <= ac_cycles + 16'h0001;
            end
            if (req_cycle && power_on_request_n_cycles != `PFR_CYC_MAX)
            begin
                power_on_request_n_cycles <= power_on_request_n_cycles + 16'h0001;
            end
        end
    end

    // ************************************************************
    // shutdown event counters
    // ************************************************************
    reg [NEV-1:0] stat_d;
    reg [4*NEV-1:0] cnt;
    // a bit that stays high counts once only
    wire [NEV-1:0] rise = shutdown_status & ~stat_d;
    reg [4*NEV-1:0] next_cnt;
    integer i;

    always @*
    begin
        next_cnt = cnt;
        for (i = 0; i < NEV; i = i + 1)
        begin
            if (rise[i] && cnt[4*i +: 4] != `PFR_CNT_MAX)
            begin
                next_cnt[4*i +: 4] = cnt[4*i +: 4] + 4'h1;
            end
        end
    end

    always @(posedge clk)
    begin
        if (!resetn)
        begin
            stat_d <= {NEV{1'b0}};
            cnt <= {4*NEV{1'b0}};
            cnt_nvm_we <= 1'b0;
            cnt_nvm_data <= 24'h00_0000;
        end
        else
        begin
            stat_d <= shutdown_status;
            cnt_nvm_we <= 1'b0;
            // the image wins over a rise in the load cycle, which is dropped
            if (cnt_load)
            begin
                cnt <= cnt_load_data[4*NEV-1:0];
            end
            else
            begin
                cnt <= next_cnt;
            end
            // a counter already at fifteen still strobes, so every event outside a load cycle reaches nvm
            if (|rise && !cnt_load)
            begin
                cnt_nvm_we <= 1'b1;
                cnt_nvm_data <= next_cnt[23:0];
            end
        end
    end

    // ************************************************************
    // record assembly
    // ************************************************************
    // the snapshot uses next_cnt so the event that shuts down is itself included
    wire [8*`PFR_REC_BYTES-1:0] rec;
    assign rec[8*`PFR_OFF_TIME +: 32] = rtc_seconds;
    assign rec[8*`PFR_OFF_AC_CYC +: 16] = ac_cycles;
    assign rec[8*`PFR_OFF_POWER_ON_REQUEST_N_CYC +: 16] = power_on_request_n_cycles;
    assign rec[8*`PFR_OFF_STATUS_WORD +: 16] = status_word;
    assign rec[8*`PFR_OFF_STATUS_IOUT +: 8] = status_iout;
    assign rec[8*`PFR_OFF_STATUS_INPUT +: 8] = status_input;
    assign rec[8*`PFR_OFF_STATUS_TEMP +: 8] = status_temp;
    assign rec[8*`PFR_OFF_STATUS_FAN +: 8] = status_fan;
    assign rec[8*`PFR_OFF_READ_VIN +: 16] = read_vin;
    assign rec[8*`PFR_OFF_READ_IIN +: 16] = read_iin;
    assign rec[8*`PFR_OFF_READ_IOUT +: 16] = read_iout;
    assign rec[8*`PFR_OFF_READ_TEMP1 +: 16] = read_temp1;
    assign rec[8*`PFR_OFF_READ_TEMP2 +: 16] = read_temp2;
    assign rec[8*`PFR_OFF_READ_FAN +: 16] = read_fan;
    assign rec[8*`PFR_OFF_READ_PIN +: 16] = read_pin;
    assign rec[8*`PFR_OFF_READ_VOUT +: 16] = read_vout;
    assign rec[8*`PFR_OFF_CNT0 +: 24] = next_cnt[23:0];
    // remaining bytes of the 38-byte slot are reserved and zero
    assign rec[8*`PFR_REC_BYTES-1:8*(`PFR_OFF_CNT2+1)] = {8*(`PFR_REC_BYTES-`PFR_OFF_CNT2-1){1'b0}};

    always @(posedge clk)
    begin
        if (!resetn)
        begin
            rec_nvm_we <= 1'b0;
            rec_nvm_data <= {8*`PFR_REC_BYTES{1'b0}};
        end
        else
        begin
            rec_nvm_we <= 1'b0;
            if (|rise && !cnt_load)
            begin
                // nvm side overwrites its one slot with the newest record on each strobe
                rec_nvm_we <= 1'b1;
                rec_nvm_data <= rec;
            end
        end
    end

endmodule // pfr_recorder
